// *** include/hls_pkg.sv ***
// Package for the host link switch configuration block: register map,
// field layouts, reset values, baud table and the carried structs.
// Assumes a 25 MHz core clock and a 32-bit APB register port.
package hls_pkg;

    localparam int CLK_HZ = 25_000_000;

    // Switch position n sits at bit n-1; a set bit means the position is ON
    localparam int SW_MODE = 0;
    localparam int SW_HSK_EN = 1;
    localparam int SW_SRQ_OR_HW = 2;
    localparam int SW_ADDR_MSB = 3;
    localparam int SW_PAR_EN = 3;
    localparam int SW_PAR_EVEN = 4;
    localparam int SW_BAUD_MSB = 5;
    localparam int SW_BAUD_LSB = 7;

    localparam logic [4:0] GPIB_RESERVED_ADDR = 5'h07;

    // Baud rates, and bit periods in core clocks, indexed by the three-bit baud code
    localparam int BAUD_RATE [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
    localparam int DIV_W = 17;
    localparam logic [DIV_W-1:0] BAUD_DIV [8] = '{
        DIV_W'(CLK_HZ / 300), DIV_W'(CLK_HZ / 600), DIV_W'(CLK_HZ / 1200),
        DIV_W'(CLK_HZ / 2400), DIV_W'(CLK_HZ / 4800), DIV_W'(CLK_HZ / 9600),
        DIV_W'(CLK_HZ / 19200), DIV_W'(CLK_HZ / 38400)};

    // APB byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_GPIB = 8'h04;
    localparam logic [7:0] REG_SERIAL = 8'h08;
    localparam logic [7:0] REG_IPADDR = 8'h0C;
    localparam logic [7:0] REG_CONTROL = 8'h10;

    // Control register fields
    localparam int CTL_LINK_EN = 0;
    localparam int CTL_USE_DHCP = 1;
    localparam logic [1:0] CTL_RESET = 2'h0;

    localparam logic [31:0] IP_RESET = 32'h0000_0000;

    typedef enum logic [0:0] {
        HLS_CAPTURE,
        HLS_RUN
    } hls_phase_t;

    typedef struct packed {
        logic srqEnable;
        logic [4:0] busAddress;
        logic addrReserved;
    } hls_gpib_cfg_t;

    typedef struct packed {
        logic handshakeEnable;
        logic hwFlowControl;
        logic swFlowControl;
        logic parityEnable;
        logic parityEven;
        logic [2:0] baudCode;
        logic [DIV_W-1:0] bitPeriod;
    } hls_serial_cfg_t;

    typedef struct packed {
        logic gpibActive;
        logic serialActive;
        logic netActive;
    } hls_link_sel_t;

    typedef struct packed {
        logic leaseValid;
        logic fromDhcp;
        logic [31:0] ipAddress;
        logic requestDhcp;
    } hls_net_t;

endpackage

// *** verilog/hls_host_link_switch_config.sv ***
// Host link switch configuration logic of the plug-in communication card.
// Assumes the switch and strap inputs are synchronous and steady around reset,
// and that a separate network engine delivers the server-assigned address.
// Behaviour
// RULE_01 - Position 1 OFF selects GPIB mode, ON selects RS-232 mode.
// RULE_02 - In GPIB mode position 3 ON enables service requests, OFF disables.
// RULE_03 - GPIB address is positions 4..8 weighted 16,8,4,2,1, position 4 MSB.
// RULE_04 - Host must not set address 7 nor duplicate another bus address.
// RULE_05 - In RS-232 mode position 2 ON enables handshaking, OFF none.
// RULE_06 - With handshaking, position 3 ON selects hardware, OFF software flow.
// RULE_07 - In RS-232 mode position 4 ON enables parity, OFF no parity.
// RULE_08 - With parity, position 5 ON selects even, OFF selects odd.
// RULE_09 - Positions 6..8 give baud code, 000..111 select 300 to 38400.
// RULE_10 - Only the connection matching position 1 is ever active; the network variant enables the network link instead.
// RULE_11 - Network variant takes its IP address from BootP or DHCP server.
// RULE_12 - Switches sampled once after reset, settings then held constant.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module hls_host_link_switch_config
    import hls_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [7:0] cfgSwitch,
    input wire logic netVariant,
    input wire logic dhcpSupported,
    input wire logic leaseStrobe,
    input wire logic leaseFromDhcp,
    input wire logic [31:0] leaseAddress,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output hls_link_sel_t linkSelect,
    output hls_gpib_cfg_t gpibConfig,
    output hls_serial_cfg_t serialConfig,
    output logic requestDhcp,
    output logic configValid
);

    typedef struct packed {
        hls_phase_t phase;
        logic [7:0] switches;
        logic isNet;
        logic [1:0] control;
        hls_link_sel_t link;
        hls_gpib_cfg_t gpib;
        hls_serial_cfg_t serial;
        hls_net_t net;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } hls_state_t;

    hls_state_t state_reg;
    hls_state_t state_next;

    logic setupPhase;
    logic accessDone;
    logic addrKnown;
    logic [31:0] readMux;

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && state_reg.ready;

    always_comb begin
        addrKnown = 1'b1;
        readMux = 32'h0000_0000;
        case (paddr)
            REG_STATUS: begin
                readMux = {16'h0000, state_reg.switches, 1'b0,
                    state_reg.phase == HLS_RUN, state_reg.isNet,
                    state_reg.link.netActive, state_reg.link.serialActive,
                    state_reg.link.gpibActive, state_reg.net.leaseValid,
                    state_reg.net.fromDhcp};
            end
            REG_GPIB: begin
                readMux = {25'h000_0000, state_reg.gpib};
            end
            REG_SERIAL: begin
                // The serial struct is 25 bits wide, so it fills bits 25:1
                readMux = {6'h00, state_reg.serial, 1'b0};
            end
            REG_IPADDR: begin
                readMux = state_reg.net.ipAddress;
            end
            REG_CONTROL: begin
                readMux = {30'h0000_0000, state_reg.control};
            end
            default: begin
                addrKnown = 1'b0;
            end
        endcase
    end

    always_comb begin
        logic linkOn;
        logic gpibMode;
        linkOn = 1'b0;
        gpibMode = 1'b0;
        state_next = state_reg;

        // Zero-wait slave: data is prepared in setup, pready stands in access
        state_next.ready = setupPhase;
        state_next.slverr = setupPhase && !addrKnown;
        state_next.rdata = (setupPhase && !pwrite) ? readMux : 32'h0000_0000;

        if (accessDone && pwrite && paddr == REG_CONTROL) begin
            state_next.control = pwdata[1:0];
        end

        case (state_reg.phase)
            HLS_CAPTURE: begin
                // First enabled cycle after reset release freezes the switches
                state_next.switches = cfgSwitch; // see RULE_12
                state_next.isNet = netVariant;
                state_next.phase = HLS_RUN; // see RULE_12
            end
            HLS_RUN: begin
                // Switches are no longer looked at until the next reset
            end
            default: begin
                state_next.phase = HLS_CAPTURE;
            end
        endcase

        // Decoding uses the held copy, so a moved switch has no effect
        gpibMode = !state_next.switches[SW_MODE]; // see RULE_01
        linkOn = state_next.phase == HLS_RUN && state_next.control[CTL_LINK_EN];

        // One connection at a time: the network link on the network variant, else picked by the mode position
        state_next.link.netActive = linkOn && state_next.isNet;
        state_next.link.gpibActive = linkOn && !state_next.isNet && gpibMode; // see RULE_10
        state_next.link.serialActive = linkOn && !state_next.isNet && !gpibMode; // see RULE_10

        state_next.gpib.srqEnable = gpibMode && state_next.switches[SW_SRQ_OR_HW]; // see RULE_02
        state_next.gpib.busAddress = gpibMode ?
            {state_next.switches[SW_ADDR_MSB], state_next.switches[SW_ADDR_MSB+1],
             state_next.switches[SW_ADDR_MSB+2], state_next.switches[SW_ADDR_MSB+3],
             state_next.switches[SW_ADDR_MSB+4]} : 5'h00; // see RULE_03
        // Reserved address is flagged only; the user is expected to avoid it
        state_next.gpib.addrReserved = gpibMode &&
            state_next.gpib.busAddress == GPIB_RESERVED_ADDR; // see RULE_04

        state_next.serial.handshakeEnable = !gpibMode &&
            state_next.switches[SW_HSK_EN]; // see RULE_05
        state_next.serial.hwFlowControl = state_next.serial.handshakeEnable &&
            state_next.switches[SW_SRQ_OR_HW]; // see RULE_06
        state_next.serial.swFlowControl = state_next.serial.handshakeEnable &&
            !state_next.switches[SW_SRQ_OR_HW]; // see RULE_06
        state_next.serial.parityEnable = !gpibMode &&
            state_next.switches[SW_PAR_EN]; // see RULE_07
        state_next.serial.parityEven = state_next.serial.parityEnable &&
            state_next.switches[SW_PAR_EVEN]; // see RULE_08
        state_next.serial.baudCode = {state_next.switches[SW_BAUD_MSB],
            state_next.switches[SW_BAUD_MSB+1], state_next.switches[SW_BAUD_LSB]}; // see RULE_09
        state_next.serial.bitPeriod = BAUD_DIV[state_next.serial.baudCode]; // see RULE_09

        // No local address setting exists; only a server lease loads it
        state_next.net.requestDhcp = state_next.isNet && dhcpSupported &&
            state_next.control[CTL_USE_DHCP]; // see RULE_11
        if (state_next.isNet && state_reg.phase == HLS_RUN && leaseStrobe) begin
            state_next.net.ipAddress = leaseAddress; // see RULE_11
            state_next.net.fromDhcp = leaseFromDhcp && state_next.net.requestDhcp;
            state_next.net.leaseValid = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg.phase <= HLS_CAPTURE;
            state_reg.switches <= 8'h00;
            state_reg.isNet <= 1'b0;
            state_reg.control <= CTL_RESET;
            state_reg.link <= '0;
            state_reg.gpib <= '0;
            state_reg.serial <= '0;
            state_reg.net <= '0;
            state_reg.net.ipAddress <= IP_RESET;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.ready <= 1'b0;
            state_reg.slverr <= 1'b0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;
    assign linkSelect = state_reg.link;
    assign gpibConfig = state_reg.gpib;
    assign serialConfig = state_reg.serial;
    assign requestDhcp = state_reg.net.requestDhcp;
    assign configValid = state_reg.phase == HLS_RUN;

endmodule

`default_nettype wire

// *** bench/hls_chk.sv ***
// Checker of the switch decode.
// Bound to the top module; clkEn is held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module hls_chk
    import hls_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] cfgSwitch,
    input wire hls_link_sel_t linkSelect,
    input wire hls_gpib_cfg_t gpibConfig,
    input wire hls_serial_cfg_t serialConfig,
    input wire logic configValid
);
    logic [7:0] s_reg;
    // Own copy of the capture, so later switch moves cannot leak in
    always_ff @(posedge mclk) begin
        if (reset_n && !configValid) begin
            s_reg <= cfgSwitch;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    a_capture_once: assert property (!configValid |=> configValid)
        else $error("no capture");
    a_cfg_held: assert property (configValid && $past(configValid) |->
        $stable(gpibConfig) && $stable(serialConfig)) else $error("config moved");
    a_srq_on: assert property (configValid |->
        gpibConfig.srqEnable == (!s_reg[0] && s_reg[2])) else $error("srq");
    a_gpib_addr: assert property (configValid && !s_reg[0] |->
        gpibConfig.busAddress == {s_reg[3], s_reg[4], s_reg[5], s_reg[6], s_reg[7]})
        else $error("address");
    a_hsk_kind: assert property (configValid |->
        serialConfig.handshakeEnable == (s_reg[0] && s_reg[1]) &&
        serialConfig.hwFlowControl == (s_reg[0] && s_reg[1] && s_reg[2])) else $error("hsk");
    a_parity_kind: assert property (configValid |->
        serialConfig.parityEnable == (s_reg[0] && s_reg[3]) &&
        serialConfig.parityEven == (s_reg[0] && s_reg[3] && s_reg[4])) else $error("parity");
    a_baud_code: assert property (configValid && s_reg[0] |->
        serialConfig.baudCode == {s_reg[5], s_reg[6], s_reg[7]}) else $error("baud");
    a_one_link: assert property ($onehot0(linkSelect))
        else $error("two links");
endmodule
bind hls_host_link_switch_config hls_chk u_chk (.mclk, .reset_n, .cfgSwitch, .linkSelect,
    .gpibConfig, .serialConfig, .configValid);
`default_nettype wire

// *** bench/hls_lease_src.sv ***
// Network engine model that hands over a server-assigned address.
// Assumes go is high for one clock per lease.
`timescale 1ns/1ps
`default_nettype none
module hls_lease_src (
    input wire logic mclk,
    input wire logic go,
    input wire logic [31:0] addrIn,
    output logic leaseStrobe = 1'h0,
    output logic leaseFromDhcp = 1'h0,
    output logic [31:0] leaseAddress = 32'h0000_0000
);
    // Address toggles outside the strobe so a stale value is never read
    always @(posedge mclk) begin
        leaseStrobe <= go;
        leaseFromDhcp <= go;
        leaseAddress <= go ? addrIn : ~leaseAddress;
    end
endmodule
`default_nettype wire

// *** bench/hls_host_link_switch_config_tb.sv ***
// Bench: switch decode in both modes, APB reads, one network lease.
// Assumes the bound checker and the lease model beside the design.
`timescale 1ns/1ps
`default_nettype none
module hls_host_link_switch_config_tb
    import hls_pkg::*;
();
    logic mclk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic netVariant = 1'h0, dhcpSupported = 1'h0, go = 1'h0, e;
    logic pready, pslverr, requestDhcp, configValid, leaseStrobe, leaseFromDhcp;
    logic [7:0] cfgSwitch = 8'h00, paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, addrIn = 32'h0000_0000, seed = 32'h0000_0035;
    logic [31:0] prdata, leaseAddress, r, x;
    hls_link_sel_t linkSelect;
    hls_gpib_cfg_t gpibConfig;
    hls_serial_cfg_t serialConfig;
    int fails = 0, n_checks = 0;
    hls_host_link_switch_config DUT (.mclk, .reset_n, .clkEn(1'h1), .cfgSwitch, .netVariant,
        .dhcpSupported, .leaseStrobe, .leaseFromDhcp, .leaseAddress, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .linkSelect, .gpibConfig, .serialConfig,
        .requestDhcp, .configValid);
    hls_lease_src host (.mclk, .go, .addrIn, .leaseStrobe, .leaseFromDhcp, .leaseAddress);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic hls_gpib_cfg_t expGpib(logic [7:0] s);
        logic [4:0] a = {s[3], s[4], s[5], s[6], s[7]};
        return s[0] ? 7'h00 : {s[2], a, a == 5'h07};
    endfunction
    function automatic hls_serial_cfg_t expSer(logic [7:0] s);
        logic [2:0] b = {s[5], s[6], s[7]};
        return {s[1], s[1] & s[2], s[1] & !s[2], s[3], s[3] & s[4], b, DIV_W'(CLK_HZ / (300 << b))};
    endfunction
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'h1) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        chk(k < 16, "hang");
        if (k >= 16) conclude();
        // Idle edge so a following call never drives psel twice in one step
        @(posedge mclk);
    endtask
    task automatic trial(input logic [7:0] s);
        reset_n <= 1'h0;
        cfgSwitch <= s;
        repeat (6) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (2) @(posedge mclk);
        repeat (2) begin
            chk(gpibConfig === expGpib(s), "gpib");
            if (s[0] && !netVariant) chk(serialConfig === expSer(s), "serial");
            apb(1'h1, REG_CONTROL, {30'h0, netVariant, 1'h1});
            cfgSwitch <= ~s;
            apb(1'h0, REG_GPIB, 32'h0000_0000);
        end
        chk(r[6:0] === expGpib(s), "gpib read");
        chk(linkSelect === (netVariant ? 3'h1 : {!s[0], s[0], 1'h0}), "link");
        $display("test %h done", s);
    endtask
    initial begin
        forever #20 mclk = ~mclk;
    end
    initial begin
        trial(8'hE0);
        trial(8'hFE);
        for (int i = 0; i < 8; i++) begin
            x = rnd();
            trial({i[0], i[1], i[2], x[4:1], 1'h1});
            trial({x[12:6], 1'h0});
        end
        apb(1'h0, 8'h40, 32'h0000_0000);
        chk(e === 1'h1 && r === 32'h0000_0000, "unmapped");
        netVariant <= 1'h1;
        dhcpSupported <= 1'h1;
        trial(8'h01);
        addrIn <= x;
        go <= 1'h1;
        @(posedge mclk);
        go <= 1'h0;
        repeat (3) @(posedge mclk);
        apb(1'h0, REG_IPADDR, 32'h0000_0000);
        chk(r === addrIn && requestDhcp === 1'h1, "lease");
        conclude();
    end
endmodule
`default_nettype wire
